// ==== design/tamper_selftest_pkg.sv ====
// Package for the tamper and self-test supervisor: states, codes, counts.
// Assumes a single 50 MHz clock domain.
package tamper_selftest_pkg;
    localparam int unsigned CLK_MHZ        = 50;
    localparam int unsigned NUM_CH         = 4;
    localparam int unsigned CNT_W          = 20;
    // Wait for the integrity checker, in microseconds
    localparam int unsigned INTEG_TIMEOUT_US = 10_000;
    localparam int unsigned INTEG_TIMEOUT_CYC = INTEG_TIMEOUT_US * CLK_MHZ;
    // Listening window after the isolation test packet, in microseconds
    localparam int unsigned ISO_WINDOW_US  = 20;
    localparam int unsigned ISO_WINDOW_CYC = ISO_WINDOW_US * CLK_MHZ;
    localparam logic [1:0]  ISO_TEST_CH    = 2'h0; // Channel 1 is index 0
    localparam logic [CNT_W-1:0] CNT_RESET = 20'h0_0000;

    // Failure codes shown to the user
    localparam logic [2:0] FAIL_NONE   = 3'h0;
    localparam logic [2:0] FAIL_INTEG  = 3'h1;
    localparam logic [2:0] FAIL_ISO    = 3'h2;
    localparam logic [2:0] FAIL_CTRL   = 3'h3;
    localparam logic [2:0] FAIL_TAMPER = 3'h4;
    localparam logic [2:0] FAIL_TOUT   = 3'h5;

    typedef enum logic [2:0] {
        ST_INTEG,
        ST_ISO_SEND,
        ST_ISO_LISTEN,
        ST_CTRL,
        ST_TAMPER_CHK,
        ST_RUN,
        ST_FAIL
    } phase_t;
endpackage

// ==== design/tamper_selftest_supervisor.sv ====
// Tamper latch and power-up self-test sequencer for a peripheral-sharing switch.
// Assumes sensor pins are asynchronous; port activity and test results are on clk_in.
// The tamper latch itself lives in backup-powered storage outside; this block
// sets it and reads it back, and runs from the backup supply with the sensors.
`timescale 1ns/1ps
`default_nettype none
module tamper_selftest_supervisor
    import tamper_selftest_pkg::*;
#(
    parameter int unsigned INTEG_TIMEOUT = INTEG_TIMEOUT_CYC
) (
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    input  wire logic              enclosure_open_in,
    input  wire logic              backup_fail_in,
    input  wire logic              tamper_store_in,
    input  wire logic              integ_done_in,
    input  wire logic              integ_ok_in,
    input  wire logic [NUM_CH-1:0] port_rx_in,
    input  wire logic              user_ctrl_ok_in,
    input  wire logic              tamper_sys_ok_in,
    input  wire logic [1:0]        user_chan_in,
    output logic                   tamper_set_out,
    output logic                   tamper_led_out,
    output logic [NUM_CH-1:0]      path_enable_out,
    output logic [1:0]             test_chan_out,
    output logic                   test_send_out,
    output logic                   fail_led_out,
    output logic [2:0]             fail_code_out,
    output logic                   fail_critical_out,
    output logic                   selftest_done_out
);
    typedef struct packed {
        logic [1:0]        sync_enc;   // [0] is the first synchroniser stage
        logic [1:0]        sync_bat;
        logic [1:0]        sync_store;
        logic              tampered;
        phase_t            phase;
        logic [CNT_W-1:0]  cnt;
        logic [NUM_CH-1:0] path;
        logic              send;
        logic [2:0]        code;
        logic              crit;
        logic              done;       // Normal switching allowed
        logic [1:0]        chan;       // Channel held for the isolation test
    } state_t;

    state_t cur;
    state_t next_cur;

    // One-hot enable for the channel the user picked
    function automatic logic [NUM_CH-1:0] onehot(input logic [1:0] ch);
        onehot = (NUM_CH)'(1) << ch;
    endfunction

    // Next-state logic; sensor levels are read only from the second stage on
    always_comb begin
        next_cur = cur;
        next_cur.send = 1'b0;
        next_cur.sync_enc = {cur.sync_enc[0], enclosure_open_in};
        next_cur.sync_bat = {cur.sync_bat[0], backup_fail_in};
        next_cur.sync_store = {cur.sync_store[0], tamper_store_in};
        // Any cause latches; nothing in this process ever clears it
        if (cur.sync_enc[1] || cur.sync_bat[1] || cur.sync_store[1]) begin
            next_cur.tampered = 1'b1;
        end
        case (cur.phase)
            ST_INTEG: begin
                next_cur.cnt = cur.cnt + 1'b1;
                if (integ_done_in) begin
                    next_cur.cnt = CNT_RESET;
                    if (integ_ok_in) begin
                        next_cur.phase = ST_ISO_SEND;
                    end else begin
                        next_cur.phase = ST_FAIL;
                        next_cur.code = FAIL_INTEG;
                    end
                end else if (cur.cnt >= (CNT_W)'(INTEG_TIMEOUT - 1)) begin
                    next_cur.phase = ST_FAIL;
                    next_cur.code = FAIL_TOUT;
                end
            end
            ST_ISO_SEND: begin
                next_cur.send = 1'b1;
                next_cur.cnt = CNT_RESET;
                next_cur.phase = ST_ISO_LISTEN;
            end
            ST_ISO_LISTEN: begin
                next_cur.cnt = cur.cnt + 1'b1;
                if ((port_rx_in & ~onehot(ISO_TEST_CH)) != '0) begin
                    next_cur.phase = ST_FAIL;
                    next_cur.code = FAIL_ISO;
                end else if (cur.cnt >= (CNT_W)'(ISO_WINDOW_CYC - 1)) begin
                    next_cur.phase = ST_CTRL;
                end
            end
            ST_CTRL: begin
                if (user_ctrl_ok_in) begin
                    next_cur.phase = ST_TAMPER_CHK;
                end else begin
                    next_cur.phase = ST_FAIL;
                    next_cur.code = FAIL_CTRL;
                end
            end
            ST_TAMPER_CHK: begin
                if (tamper_sys_ok_in) begin
                    next_cur.phase = ST_RUN;
                end else begin
                    next_cur.phase = ST_FAIL;
                    next_cur.code = FAIL_TAMPER;
                end
            end
            ST_RUN: begin
                // Selection is taken one edge late; a tamper closes it again below
                next_cur.path = onehot(user_chan_in);
            end
            default: begin // ST_FAIL holds until the next reset
                next_cur.crit = 1'b1;
            end
        endcase
        // Registered from the next phase, so the done flag rises one edge before the enable opens
        next_cur.done = (next_cur.phase == ST_RUN);
        // Failure or tamper closes every path in the same cycle as it is seen
        if (next_cur.phase != ST_RUN || next_cur.tampered) begin
            next_cur.path = '0;
        end
    end

    // Reset puts every path closed; the tamper copy reloads from backup storage
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cur <= '{sync_enc: 2'h0, sync_bat: 2'h0, sync_store: 2'h0, tampered: 1'b0,
                     phase: ST_INTEG, cnt: CNT_RESET, path: '0, send: 1'b0,
                     code: FAIL_NONE, crit: 1'b0, done: 1'b0,
                     chan: ISO_TEST_CH};
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state flops
    assign tamper_set_out    = cur.tampered;
    assign tamper_led_out    = cur.tampered;
    assign path_enable_out   = cur.path;
    // The test channel sits in a flop so the pin never sees decode glitches
    assign test_chan_out     = cur.chan;
    assign test_send_out     = cur.send;
    assign fail_led_out      = cur.crit;
    assign fail_code_out     = cur.code;
    assign fail_critical_out = cur.crit;
    assign selftest_done_out = cur.done;

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // Tamper latch and path-closure checks; a cause reaches the latch three edges after its pin
    backup_fail_latch_a: assert property ($rose(cur.sync_bat[1]) |=> tamper_set_out)
        else $error("backup failure did not latch tamper");
    enclosure_latch_a: assert property (cur.sync_enc[1] |=> tamper_led_out)
        else $error("enclosure open did not latch tamper");
    tamper_paths_closed_a: assert property (tamper_set_out |-> path_enable_out == '0)
        else $error("path open while tampered");
    tamper_permanent_a: assert property (tamper_set_out |=> tamper_set_out)
        else $error("tamper state cleared");
    tamper_indication_a: assert property (cur.sync_store[1] |=> tamper_led_out)
        else $error("stored tamper not shown to the user");
    store_reload_a: assert property (tamper_store_in [*3] |=> tamper_set_out)
        else $error("stored tamper not reloaded");
    no_path_before_test_a: assert property (!selftest_done_out |-> path_enable_out == '0)
        else $error("path open before self-test done");

    // Self-test sequencing: send, verdicts and hand-over to normal switching
    iso_leak_fail_a: assert property (
        cur.phase == ST_ISO_LISTEN && port_rx_in[NUM_CH-1:1] != '0
        |=> cur.phase == ST_FAIL ##1 fail_code_out == FAIL_ISO && fail_led_out)
        else $error("isolation leak not flagged");
    iso_send_pulse_a: assert property ($rose(test_send_out) |=> !test_send_out)
        else $error("test send longer than one cycle");
    fail_disable_a: assert property (fail_led_out |-> path_enable_out == '0 && !selftest_done_out)
        else $error("failed unit still operating");
    ctrl_fail_a: assert property (
        cur.phase == ST_CTRL && !user_ctrl_ok_in |=> ##1 fail_code_out == FAIL_CTRL)
        else $error("user control failure not reported");
    integ_pass_send_a: assert property (
        cur.phase == ST_INTEG && integ_done_in && integ_ok_in |=> ##1 test_send_out)
        else $error("test packet not sent after integrity pass");
    integ_timeout_a: assert property (
        cur.phase == ST_INTEG && !integ_done_in && cur.cnt == (CNT_W)'(INTEG_TIMEOUT - 1)
        |=> fail_code_out == FAIL_TOUT)
        else $error("integrity timeout not reported");
    run_path_select_a: assert property (
        selftest_done_out ##1 selftest_done_out && !tamper_set_out
        |-> path_enable_out == onehot($past(user_chan_in)))
        else $error("enabled path differs from selected channel");
    fail_hold_a: assert property (
        fail_led_out |=> fail_led_out && $stable(fail_code_out))
        else $error("failure indication did not hold");
    fail_indicate_a: assert property (
        cur.phase == ST_FAIL |=> fail_led_out && fail_critical_out)
        else $error("failure not indicated");

    reach_run_c: cover property (cur.phase == ST_TAMPER_CHK ##1 selftest_done_out);
    iso_fail_c: cover property (fail_code_out == FAIL_ISO);
    tamper_run_c: cover property (selftest_done_out ##1 tamper_set_out);
    integ_fail_c: cover property (fail_code_out == FAIL_INTEG);
    tamper_reload_c: cover property (tamper_store_in ##3 tamper_set_out);
endmodule
`default_nettype wire

// ==== tb/tamper_partner_model.sv ====
// Far side of the supervisor: backup-powered tamper latch and computer ports.
// Assumes one clock; the latch has no reset, as it lives on the backup supply.
`timescale 1ns/1ps
`default_nettype none
module tamper_partner_model
    import tamper_selftest_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              clear_in,
    input  wire logic              tamper_set_in,
    input  wire logic              test_send_in,
    input  wire logic [NUM_CH-1:0] leak_in,
    output logic                   tamper_store_out,
    output logic [NUM_CH-1:0]      port_rx_out
);
    logic [2:0] hold = 3'h0;
    // Latch survives every supervisor reset; clear only models a fresh unit
    always_ff @(posedge clk_in) begin
        if (clear_in) begin
            tamper_store_out <= 1'b0;
        end else if (tamper_set_in) begin
            tamper_store_out <= 1'b1;
        end
    end
    // Test packet lands on channel 1; leak_in models crosstalk to the others
    always_ff @(posedge clk_in) begin
        if (test_send_in) begin
            hold <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end
    assign port_rx_out = (hold != 3'h0) ? {leak_in[NUM_CH-1:1], 1'b1} : '0;
endmodule
`default_nettype wire

// ==== tb/test_tamper_selftest_supervisor.sv ====
// Self-checking bench: self-test outcomes, tamper latching and persistence.
// Assumes the partner model holds the tamper latch across resets.
`timescale 1ns/1ps
`default_nettype none
module test_tamper_selftest_supervisor
    import tamper_selftest_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, encl = 1'b0, bfail = 1'b0, clr = 1'b1;
    logic idone = 1'b0, iok = 1'b0, ucok = 1'b0, tsok = 1'b0, tset, tled, tsend;
    logic fled, fcrit, done, store;
    logic [7:0] sends = 8'h00;
    logic [1:0] uchan = 2'h0, tchan;
    logic [2:0] fcode;
    logic [3:0] leak = 4'h0, path, rx;
    logic [31:0] seed = 32'he183;
    logic [5:0] cases [6] = '{6'h1B, 6'h13, 6'h03, 6'h1F, 6'h19, 6'h1A};
    logic [2:0] codes [6] = '{FAIL_NONE, FAIL_INTEG, FAIL_TOUT, FAIL_ISO, FAIL_CTRL, FAIL_TAMPER};
    int err_count = 0, total_checks = 0;
    tamper_selftest_supervisor #(.INTEG_TIMEOUT(20)) u_tamper_selftest_supervisor (
        .clk_in(clk), .reset_n_in(rst_n), .enclosure_open_in(encl), .backup_fail_in(bfail),
        .tamper_store_in(store), .integ_done_in(idone), .integ_ok_in(iok), .port_rx_in(rx),
        .user_ctrl_ok_in(ucok), .tamper_sys_ok_in(tsok), .user_chan_in(uchan),
        .tamper_set_out(tset), .tamper_led_out(tled), .path_enable_out(path),
        .test_chan_out(tchan), .test_send_out(tsend), .fail_led_out(fled),
        .fail_code_out(fcode), .fail_critical_out(fcrit), .selftest_done_out(done));
    tamper_partner_model u_tamper_partner_model (.clk_in(clk), .clear_in(clr),
        .tamper_set_in(tset), .test_send_in(tsend), .leak_in(leak),
        .tamper_store_out(store), .port_rx_out(rx));
    // Free-running 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Reset for six cycles, then wait for a verdict; bound covers the 1000-cycle window
    task automatic boot();
        int n;
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        n = 0;
        sends = 8'h00;
        while (done !== 1'b1 && fled !== 1'b1 && n < 1500) begin
            @(negedge clk);
            n++;
            if (tsend === 1'b1) begin
                sends++;
            end
        end
        if (n == 1500) begin
            err_count++;
            conclude();
        end
        @(negedge clk);
    endtask
    initial begin
        // Every self-test outcome; leak cases always leak on port 2, plus random leaks on ports 3..4
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            {idone, iok, ucok, tsok} = {cases[i][4:3], cases[i][1:0]};
            leak = cases[i][2] ? {seed[2:0] | 3'h1, 1'b0} : 4'h0;
            uchan = seed[5:4];
            boot();
            check(fcode, codes[i]);
            check({fled, fcrit}, {2{codes[i] != FAIL_NONE}});
            check(done, codes[i] == FAIL_NONE);
            check(path, (codes[i] == FAIL_NONE) ? 4'h1 << uchan : 4'h0);
            check(tchan, ISO_TEST_CH);
            check(sends, {7'h00, codes[i] != FAIL_INTEG && codes[i] != FAIL_TOUT});
            $display("Self-test case %0d done", i);
        end
        // Enclosure then backup failure: latch, block, and survive a reset
        for (int s = 0; s < 2; s++) begin
            clr = 1'b1;
            {idone, iok, ucok, tsok, leak} = {4'hF, 4'h0};
            boot();
            clr = 1'b0;
            for (int k = 0; k < 8; k++) begin
                seed = xs(seed);
                uchan = seed[1:0];
                @(negedge clk);
                @(negedge clk);
                check(path, 4'h1 << uchan);
            end
            {encl, bfail} = (s == 0) ? 2'b10 : 2'b01;
            repeat (4) @(negedge clk);
            check({tled, tset, path}, {2'b11, 4'h0});
            {encl, bfail} = 2'b00;
            boot();
            repeat (4) @(negedge clk);
            check({tled, path}, {1'b1, 4'h0});
            $display("Tamper case %0d done", s);
        end
        conclude();
    end
endmodule
`default_nettype wire
